// File: testbench/skip_exec_monitor.sv
`timescale 1ns/1ps
module skip_exec_monitor (
	// Clock and inputs
	input logic ref_clk,
	input logic rst_n,
	input logic [15:0] instr_word,
	input logic acc_load,
	// Core state
	input skip_exec_pkg::phase_type q_phase,
	input logic [7:0] accumulator,
	input logic msb_flag,
	input logic all_clear_flag,
	input logic skip_active,
	input logic cycle_done
);
	localparam skip_exec_pkg::phase_type dec = skip_exec_pkg::PH_DECODE;
	localparam skip_exec_pkg::phase_type wr = skip_exec_pkg::PH_WRITE;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	sequence take(logic [6:0] op);
		q_phase == dec && !skip_active && instr_word[15:9] == op;
	endsequence
	a_phase_wrap: assert property (q_phase == wr |=> q_phase == dec && cycle_done)
		else $error("bad wrap");
	a_phase_step: assert property (q_phase != wr |=> q_phase == $past(q_phase) + 1)
		else $error("bad step");
	a_inv_flags: assert property (take(7'h0E) |-> ##4 msb_flag == accumulator[7] &&
		all_clear_flag == (accumulator == 8'h00)) else $error("bad flags");
	a_cmp_quiet: assert property (take(7'h31) |=> $stable({accumulator, msb_flag})[*4])
		else $error("compare wrote");
	a_acc_source: assert property (!$stable(accumulator) |-> $past(acc_load) ||
		$past(q_phase) == wr) else $error("stray acc");
	a_skip_cause: assert property ($rose(skip_active) |-> $past(instr_word[15:9], 4) == 7'h31)
		else $error("stray skip");
	a_skip_length: assert property ($rose(skip_active) |-> skip_active[*4] ##1
		(!skip_active or skip_active[*4] ##1 !skip_active)) else $error("skip length");
	a_skip_frozen: assert property (skip_active && !acc_load |=> $stable(accumulator))
		else $error("flushed write");
endmodule

bind skip_exec skip_exec_monitor skip_exec_monitor_inst (.ref_clk, .rst_n, .instr_word,
	.acc_load, .q_phase, .accumulator, .msb_flag, .all_clear_flag, .skip_active, .cycle_done);

// File: testbench/skip_exec_tb.sv
`timescale 1ns/1ps
module skip_exec_tb;
	logic ref_clk, rst_n, next_two_word, extended_enable, acc_load;
	logic msb_flag, all_clear_flag, skip_active, cycle_done;
	logic [15:0] instr_word;
	logic [3:0] bank_pointer;
	logic [11:0] index_base, t;
	logic [7:0] acc_load_value, accumulator, v, f;
	skip_exec_pkg::phase_type q_phase;
	int errors, n_tests;
	skip_exec skip_exec_inst (.ref_clk, .rst_n, .instr_word, .next_two_word, .extended_enable,
		.bank_pointer, .index_base, .acc_load, .acc_load_value, .q_phase, .accumulator,
		.msb_flag, .all_clear_flag, .skip_active, .cycle_done);
	initial begin
		ref_clk = 0;
		forever #20 ref_clk = ~ref_clk;
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED %0t %h %h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test;
		$display("%0d checks %0d errors", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Idle zero word after each take, else it would run twice
	task automatic issue(input logic [15:0] w, input logic ext, input logic [11:0] base);
		for (int i = 0; i < 4 && q_phase !== skip_exec_pkg::PH_DECODE; i++)
			@(negedge ref_clk);
		instr_word = w;
		extended_enable = ext;
		index_base = base;
		@(negedge ref_clk);
		instr_word = 16'h0000;
		repeat (3) @(negedge ref_clk);
	endtask
	initial begin
		#200000;
		errors++;
		end_of_test;
	end
	initial begin
		{instr_word, next_two_word, extended_enable, bank_pointer, index_base} = '0;
		{acc_load, acc_load_value, rst_n, errors, n_tests} = '0;
		void'($urandom(67039));
		repeat (4) @(negedge ref_clk);
		rst_n = 1;
		for (int i = 0; i < 6; i++) begin
			t = i == 0 ? 12'hF60 : 12'($urandom);
			f = i == 0 ? 8'h5F : 8'($urandom_range(95));
			bank_pointer = t[11:8];
			issue({6'h07, 2'b01, t[7:0]}, 1'b0, '0);
			v = accumulator;
			issue({6'h07, 2'b10, f}, 1'b1, t - 12'(f));
			check(accumulator, v);
			check({6'h00, msb_flag, all_clear_flag}, {6'h00, v[7], v == 8'h00});
			issue({6'h07, 1'b0, t < 12'hF60, t[7:0]}, 1'b1, '0);
			check(accumulator, ~v);
			for (int k = 0; k < 3; k++) begin
				acc_load_value = k == 2 ? ~v : v;
				acc_load = 1;
				@(negedge ref_clk);
				acc_load = 0;
				next_two_word = k == 1;
				issue({7'h31, 1'b1, t[7:0]}, 1'b0, '0);
				check({7'h00, skip_active}, {7'h00, k < 2});
				repeat (k == 2 ? 1 : k + 1) issue({6'h07, 2'b01, t[7:0]}, 1'b0, '0);
				check(accumulator, k == 2 ? ~v : v);
				issue({6'h07, 2'b01, t[7:0]}, 1'b0, '0);
				check(accumulator, ~v);
			end
			$display("test %0d done", i);
		end
		end_of_test;
	end
endmodule

// File: verilog/data_port_if.sv
`timescale 1ns/1ps
`include "skip_exec_cfg.svh"

interface data_port_if;
	logic [`ADDR_W-1:0] addr;
	logic rd_en;
	logic [7:0] rdata;
	logic wr_en;
	logic [7:0] wdata;

	modport requester (
		output addr,
		output rd_en,
		output wr_en,
		output wdata,
		input rdata
	);

	modport store (
		input addr,
		input rd_en,
		input wr_en,
		input wdata,
		output rdata
	);
endinterface

// File: verilog/data_store.sv
`timescale 1ns/1ps
`include "skip_exec_cfg.svh"

module data_store (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Access port
	data_port_if.store port
);
	localparam int DEPTH = 1 << `ADDR_W;

	// Powers up cleared so every read returns known data
	logic [7:0] mem [0:DEPTH-1] = '{default: 8'h00};

	// Array is not reset; only the read register is
	always_ff @(posedge ref_clk) begin
		if (port.wr_en) begin
			mem[port.addr] <= port.wdata;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			port.rdata <= 8'h00;
		end else if (port.rd_en) begin
			port.rdata <= mem[port.addr];
		end
	end
endmodule

// File: verilog/skip_exec.sv
`timescale 1ns/1ps
`include "skip_exec_cfg.svh"

// Summary of operation
// - Invert opcode complements byte, sets two flags
// - Sink bit zero to accumulator, one to register
// - Window bit zero access bank, one bank_pointer
// - Extended mode, low offsets use indexed addressing
// - Compare-skip takes one, two or three cycles
// - Compare cycle: decode, read, process, no write
// - Equal compare turns next instruction into no-op
module skip_exec (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Instruction stream
	input wire logic [15:0] instr_word,
	input wire logic next_two_word,
	// Addressing controls
	input wire logic extended_enable,
	input wire logic [`BANK_W-1:0] bank_pointer,
	input wire logic [`ADDR_W-1:0] index_base,
	// Accumulator preload
	input wire logic acc_load,
	input wire logic [7:0] acc_load_value,
	// Core state
	output skip_exec_pkg::phase_type q_phase,
	output logic [7:0] accumulator,
	output logic msb_flag,
	output logic all_clear_flag,
	output logic skip_active,
	output logic cycle_done
);
	skip_exec_pkg::op_type op;
	skip_exec_pkg::exec_state_type state;
	logic sink;
	logic [`ADDR_W-1:0] op_addr;
	logic [7:0] processed;
	logic equal;
	logic [1:0] skip_left;

	data_port_if mem_port ();

	data_store store_inst (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.port(mem_port)
	);

	function automatic logic [`ADDR_W-1:0] operand_address(
		input logic [15:0] word,
		input logic ext_en,
		input logic [`BANK_W-1:0] bank,
		input logic [`ADDR_W-1:0] base
	);
		logic [7:0] f;
		f = word[`FREG_MSB:`FREG_LSB];
		if (word[`WINDOW_BIT]) begin
			operand_address = {bank, f};
		end else if (ext_en && f <= `INDEX_LIMIT) begin
			operand_address = base + {4'h0, f};
		end else if (f >= `ACCESS_SPLIT) begin
			operand_address = {`ACCESS_HIGH_BANK, f};
		end else begin
			operand_address = {`ACCESS_LOW_BANK, f};
		end
	endfunction

	function automatic skip_exec_pkg::op_type decode(input logic [15:0] word);
		if (word[`INV_OPC_MSB:`INV_OPC_LSB] == `INV_OPC_VAL) begin
			decode = skip_exec_pkg::OP_INVERT;
		end else if (word[`CMP_OPC_MSB:`CMP_OPC_LSB] == `CMP_OPC_VAL) begin
			decode = skip_exec_pkg::OP_COMPARE;
		end else begin
			decode = skip_exec_pkg::OP_NONE;
		end
	endfunction

	// Four clocks make one instruction cycle
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			q_phase <= skip_exec_pkg::PH_DECODE;
		end else begin
			case (q_phase)
				skip_exec_pkg::PH_DECODE: q_phase <= skip_exec_pkg::PH_READ;
				skip_exec_pkg::PH_READ: q_phase <= skip_exec_pkg::PH_PROCESS;
				skip_exec_pkg::PH_PROCESS: q_phase <= skip_exec_pkg::PH_WRITE;
				default: q_phase <= skip_exec_pkg::PH_DECODE;
			endcase
		end
	end

	// Decode phase; a flushed word becomes a no-op
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			op <= skip_exec_pkg::OP_NONE;
			sink <= 1'b0;
			op_addr <= '0;
		end else if (q_phase == skip_exec_pkg::PH_DECODE) begin
			if (state == skip_exec_pkg::ST_SKIP) begin
				op <= skip_exec_pkg::OP_NONE;
			end else begin
				op <= decode(instr_word);
			end
			sink <= instr_word[`SINK_BIT];
			op_addr <= operand_address(instr_word, extended_enable, bank_pointer, index_base);
		end
	end

	// Read phase issues the operand fetch for both opcodes
	assign mem_port.addr = op_addr;
	assign mem_port.rd_en = (q_phase == skip_exec_pkg::PH_READ) &&
		(op != skip_exec_pkg::OP_NONE);

	// Process phase
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			processed <= 8'h00;
			equal <= 1'b0;
		end else if (q_phase == skip_exec_pkg::PH_PROCESS) begin
			processed <= ~mem_port.rdata;
			equal <= (mem_port.rdata == accumulator);
		end
	end

	// Write phase; compare never writes
	assign mem_port.wr_en = (q_phase == skip_exec_pkg::PH_WRITE) &&
		(op == skip_exec_pkg::OP_INVERT) && sink;
	assign mem_port.wdata = processed;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			accumulator <= `ACC_RESET;
		end else if (q_phase == skip_exec_pkg::PH_WRITE &&
			op == skip_exec_pkg::OP_INVERT && !sink) begin
			accumulator <= processed;
		end else if (acc_load) begin
			accumulator <= acc_load_value;
		end
	end

	// Only the sign and zero flags move
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			msb_flag <= 1'b0;
			all_clear_flag <= 1'b0;
		end else if (q_phase == skip_exec_pkg::PH_WRITE &&
			op == skip_exec_pkg::OP_INVERT) begin
			msb_flag <= processed[7];
			all_clear_flag <= (processed == 8'h00);
		end
	end

	// Skip sequencing: one flushed cycle, two over a two-word instruction
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= skip_exec_pkg::ST_RUN;
			skip_left <= 2'h0;
			skip_active <= 1'b0;
		end else if (q_phase == skip_exec_pkg::PH_WRITE) begin
			case (state)
				skip_exec_pkg::ST_RUN: begin
					if (op == skip_exec_pkg::OP_COMPARE && equal) begin
						state <= skip_exec_pkg::ST_SKIP;
						skip_active <= 1'b1;
						skip_left <= next_two_word ? `SKIP_TWO : `SKIP_ONE;
					end
				end
				default: begin
					skip_left <= skip_left - 2'h1;
					if (skip_left == `SKIP_ONE) begin
						state <= skip_exec_pkg::ST_RUN;
						skip_active <= 1'b0;
					end
				end
			endcase
		end
	end

	// Registered status output
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cycle_done <= 1'b0;
		end else begin
			cycle_done <= (q_phase == skip_exec_pkg::PH_WRITE);
		end
	end
endmodule

// File: verilog/skip_exec_cfg.svh
`ifndef SKIP_EXEC_CFG_SVH
`define SKIP_EXEC_CFG_SVH

// Opcode fields
`define INV_OPC_MSB 15
`define INV_OPC_LSB 10
`define INV_OPC_VAL 6'h07
`define CMP_OPC_MSB 15
`define CMP_OPC_LSB 9
`define CMP_OPC_VAL 7'h31
`define SINK_BIT 9
`define WINDOW_BIT 8
`define FREG_MSB 7
`define FREG_LSB 0

// Addressing
`define ADDR_W 12
`define BANK_W 4
`define INDEX_LIMIT 8'h5F
`define ACCESS_SPLIT 8'h60
`define ACCESS_HIGH_BANK 4'hF
`define ACCESS_LOW_BANK 4'h0

// Accumulator reset value and skip counts
`define ACC_RESET 8'h00
`define SKIP_ONE 2'h1
`define SKIP_TWO 2'h2

`endif

// File: verilog/skip_exec_pkg.sv
package skip_exec_pkg;
	typedef enum logic [1:0] {
		PH_DECODE,
		PH_READ,
		PH_PROCESS,
		PH_WRITE
	} phase_type;

	typedef enum logic [1:0] {
		OP_NONE,
		OP_INVERT,
		OP_COMPARE
	} op_type;

	typedef enum logic {
		ST_RUN,
		ST_SKIP
	} exec_state_type;
endpackage
